// ==== logic/error_mask_pwm_angle_config.sv ====
// Functional notes
// - Set mask bits keep faults off summary
// - Warning mask suppresses caution summary bit
// - Frame checksum checked only when enabled
// - Optional ignore of seventeenth serial clock
// - Turns angle filtered or unfiltered by select
// - Coded supply input ignored when disabled
// - Offset before or after correction stage
// - Span bit picks 22.5 or 45 degrees
// - Correction applied only when enabled
// - Fault tristates PWM until reset/enable clear
// - Fault halves carrier, outputs error duty
// - Fault response only with fault enable
// - PWM angle optionally through deadband filter
// - Carrier from rate and band fields
// - PWM pin tristate unless enabled
// - Zero offset subtracted from angle
// - Deadband threshold in four fine units
// - Direction bit reverses angle sense
// - Die flip adds half turn last
// - Average two to N, N capped 12
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`include "cfg_bank_defines.svh"
`default_nettype none
module error_mask_pwm_angle_config #(
    parameter int PWM_UNIT = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire logic [11:0] raw_angle,
    input wire logic [11:0] correction,
    input wire logic [23:0] fault_active,
    input wire logic [23:0] warning_active,
    input wire logic [7:0] fault_duty,
    input wire logic frame_done,
    input wire logic frame_check_ok,
    input wire logic coded_valid,
    output logic summary_fault_flag,
    output logic caution_summary_bit,
    output logic frame_check_enable,
    output logic extra_clock_ignore,
    output logic coded_input_disable,
    output logic frame_check_error,
    output logic coded_accept,
    output logic [11:0] angle,
    output logic angle_valid,
    output logic [11:0] turn_angle_register,
    output logic pwm_out,
    output logic pwm_oe,
    output cfg_bank_pkg::pwm_mode_t pwm_mode
);
    import cfg_bank_pkg::*;

    initial begin
        if (PWM_UNIT < 1 || PWM_UNIT > 32) begin
            $error("PWM_UNIT out of range");
        end
    end

    localparam logic [17:0] UNIT = 18'(PWM_UNIT);

    state_t s_q;
    state_t s_d;

    logic acc_phase;
    logic [9:0] idx;
    logic hit_mask;
    logic hit_pwi;
    logic hit_ang;
    logic hit_stat;
    logic [11:0] ofs;
    logic [11:0] corr;
    logic [11:0] a_pre;
    logic [11:0] a_lin;
    logic [11:0] a_ofs;
    logic [11:0] a_dir;
    logic [11:0] diff;
    logic [11:0] mag;
    logic [11:0] held_n;
    logic [11:0] fin_unf;
    logic [11:0] fin_flt;
    logic [11:0] flip;
    logic [3:0] depth;
    logic [12:0] last;
    logic [24:0] sum;
    logic [17:0] period;
    logic [17:0] hi_time;
    logic [29:0] prod;
    logic err_on;
    logic [11:0] pwm_ang_n;

    assign acc_phase = psel && penable;
    assign idx = paddr[11:2];
    assign hit_mask = (idx == `IDX_MASK);
    assign hit_pwi = (idx == `IDX_PWI);
    assign hit_ang = (idx == `IDX_ANG);
    assign hit_stat = (idx == `IDX_STATUS);

    always_comb begin
        s_d = s_q;
        // Bus slave, one wait cycle then answer
        s_d.ready = acc_phase && !s_q.ready;
        s_d.slverr = 1'b0;
        if (acc_phase && !s_q.ready) begin
            s_d.slverr = !(hit_mask || hit_pwi || hit_ang || hit_stat);
            if (hit_mask) begin
                s_d.rdata = {8'h00, s_q.msk};
            end else if (hit_pwi) begin
                s_d.rdata = {8'h00, s_q.pwm_interface_config};
            end else if (hit_ang) begin
                s_d.rdata = {8'h00, s_q.direction_offset_config};
            end else if (hit_stat) begin
                s_d.rdata = {5'h00, s_q.trist, s_q.caution, s_q.fault, s_q.turn, s_q.angle};
            end else begin
                s_d.rdata = 32'h0000_0000;
            end
        end
        if (acc_phase && s_q.ready && pwrite) begin
            if (hit_mask) begin
                s_d.msk = pwdata[23:0] & `MASK_WR;
            end
            if (hit_pwi) begin
                s_d.pwm_interface_config = pwdata[23:0] & `PWI_WR;
            end
            if (hit_ang) begin
                s_d.direction_offset_config = pwdata[23:0] & `ANG_WR;
            end
        end

        // Summary flags
        s_d.fault = |(fault_active & ~s_q.msk & ~24'h00_0800);
        s_d.caution = |warning_active && !s_q.msk[`MSK_WARN];

        // Serial port options
        s_d.chk_en = s_q.pwm_interface_config[`PWI_CHK];
        s_d.clk_ign = s_q.pwm_interface_config[`PWI_S17];
        s_d.coded_dis = s_q.pwm_interface_config[`PWI_DM];
        s_d.chk_err = frame_done && s_q.pwm_interface_config[`PWI_CHK] && !frame_check_ok;
        s_d.coded_acc = coded_valid && !s_q.pwm_interface_config[`PWI_DM];

        // Angle path
        ofs = s_q.direction_offset_config[`ANG_OFS_LO +: 12];
        a_pre = s_q.pwm_interface_config[`PWI_ZAL] ? raw_angle : raw_angle - ofs;
        if (s_q.pwm_interface_config[`PWI_LS]) begin
            corr = {{2{correction[11]}}, correction[11:2]};
        end else begin
            corr = {{3{correction[11]}}, correction[11:3]};
        end
        a_lin = s_q.pwm_interface_config[`PWI_ELI] ? a_pre - corr : a_pre;
        a_ofs = s_q.pwm_interface_config[`PWI_ZAL] ? a_lin - ofs : a_lin;
        a_dir = s_q.direction_offset_config[`ANG_DIR] ? 12'h000 - a_ofs : a_ofs;
        diff = a_dir - s_q.held;
        mag = diff[11] ? 12'h000 - diff : diff;
        // Threshold LSB is four units at 14 bits, one unit here
        if (mag > {6'h00, s_q.direction_offset_config[`ANG_HYS_LO +: 6]}) begin
            held_n = a_dir;
        end else begin
            held_n = s_q.held;
        end
        flip = s_q.direction_offset_config[`ANG_FLIP] ? `HALF_TURN : 12'h000;
        fin_unf = a_dir + flip;
        fin_flt = held_n + flip;
        pwm_ang_n = s_q.pwm_interface_config[`PWI_PHE] ? fin_flt : fin_unf;

        // Averaging
        depth = s_q.direction_offset_config[`ANG_AVG_LO +: 4];
        if (depth > `AVG_MAX) begin
            depth = `AVG_MAX;
        end
        last = 13'((14'h0001 << depth) - 14'h0001);
        sum = {1'b0, s_q.avg_acc} + {13'h0000, fin_unf};
        s_d.angle_valid = 1'b0;
        if (sample_valid) begin
            s_d.held = held_n;
            s_d.turn = s_q.pwm_interface_config[`PWI_TRN] ? fin_flt : fin_unf;
            s_d.pwm_angle = pwm_ang_n;
            if (s_q.avg_cnt >= last) begin
                s_d.angle = 12'(sum >> depth);
                s_d.angle_valid = 1'b1;
                s_d.avg_acc = 24'h00_0000;
                s_d.avg_cnt = 13'h0000;
            end else begin
                s_d.avg_acc = sum[23:0];
                s_d.avg_cnt = s_q.avg_cnt + 13'h0001;
            end
        end

        // PWM fault handling
        err_on = s_q.fault;
        if (!s_q.pwm_interface_config[`PWI_PEO]) begin
            s_d.trist = 1'b0;
            s_d.mode = pwm_normal;
        end else if (s_q.trist || (err_on && !s_q.pwm_interface_config[`PWI_PES])) begin
            s_d.trist = 1'b1;
            s_d.mode = pwm_tristate;
        end else if (err_on) begin
            s_d.mode = pwm_fault_duty;
        end else begin
            s_d.mode = pwm_normal;
        end

        // PWM carrier
        period = 18'(18'({14'h0000, s_q.pwm_interface_config[`PWI_FRQ_LO +: 4]} + 18'h0_0001) * UNIT);
        period = period << s_q.pwm_interface_config[`PWI_BND_LO +: 3];
        if (s_q.mode == pwm_fault_duty) begin
            period = period << 1;
            prod = 30'(period) * {22'h00_0000, fault_duty};
            hi_time = prod[25:8];
        end else begin
            prod = 30'(period) * {18'h0_0000, s_q.pwm_angle};
            hi_time = prod[29:12];
        end
        if (s_q.pwm_cnt >= period - 18'h0_0001) begin
            s_d.pwm_cnt = 18'h0_0000;
        end else begin
            s_d.pwm_cnt = s_q.pwm_cnt + 18'h0_0001;
        end
        s_d.pwm_oe = s_q.pwm_interface_config[`PWI_PEN] && s_d.mode != pwm_tristate;
        s_d.pwm_out = s_d.pwm_oe && (s_q.pwm_cnt < hi_time);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.msk <= `MASK_RST;
            s_q.pwm_interface_config <= `PWI_RST;
            s_q.direction_offset_config <= `ANG_RST;
            s_q.mode <= pwm_normal;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.slverr;
    assign summary_fault_flag = s_q.fault;
    assign caution_summary_bit = s_q.caution;
    assign frame_check_enable = s_q.chk_en;
    assign extra_clock_ignore = s_q.clk_ign;
    assign coded_input_disable = s_q.coded_dis;
    assign frame_check_error = s_q.chk_err;
    assign coded_accept = s_q.coded_acc;
    assign angle = s_q.angle;
    assign angle_valid = s_q.angle_valid;
    assign turn_angle_register = s_q.turn;
    assign pwm_out = s_q.pwm_out;
    assign pwm_oe = s_q.pwm_oe;
    assign pwm_mode = s_q.mode;
endmodule
`default_nettype wire

// ==== include/cfg_bank_defines.svh ====
`ifndef CFG_BANK_DEFINES_SVH
`define CFG_BANK_DEFINES_SVH
// Register indices, byte address is four times the index
`define IDX_MASK 10'h01a
`define IDX_PWI 10'h01b
`define IDX_ANG 10'h01c
`define IDX_STATUS 10'h010
// Writable bits of each word
`define MASK_WR 24'hdf_fc00
`define PWI_WR 24'hff_7fff
`define ANG_WR 24'hff_ffff
// Reset values
`define MASK_RST 24'h00_0000
`define PWI_RST 24'h00_0000
`define ANG_RST 24'h00_0000
// Error mask word
`define MSK_WARN 11
// Interface word
`define PWI_CHK 0
`define PWI_S17 1
`define PWI_TRN 2
`define PWI_DM 3
`define PWI_ZAL 7
`define PWI_LS 10
`define PWI_ELI 11
`define PWI_PES 12
`define PWI_PEO 13
`define PWI_PHE 14
`define PWI_FRQ_LO 16
`define PWI_BND_LO 20
`define PWI_PEN 23
// Angle word
`define ANG_OFS_LO 0
`define ANG_HYS_LO 12
`define ANG_DIR 18
`define ANG_FLIP 19
`define ANG_AVG_LO 20
// Timing and limits
`define AVG_MAX 4'h c
`define HALF_TURN 12'h800
`endif

// ==== include/cfg_bank_pkg.sv ====
package cfg_bank_pkg;
    typedef enum logic [1:0] {
        pwm_normal,
        pwm_fault_duty,
        pwm_tristate
    } pwm_mode_t;

    typedef struct packed {
        logic [23:0] msk;
        logic [23:0] pwm_interface_config;
        logic [23:0] direction_offset_config;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic fault;
        logic caution;
        logic chk_en;
        logic clk_ign;
        logic coded_dis;
        logic chk_err;
        logic coded_acc;
        logic [11:0] held;
        logic [11:0] angle;
        logic angle_valid;
        logic [11:0] turn;
        logic [11:0] pwm_angle;
        logic [23:0] avg_acc;
        logic [12:0] avg_cnt;
        logic [17:0] pwm_cnt;
        logic pwm_out;
        logic pwm_oe;
        logic trist;
        pwm_mode_t mode;
    } state_t;
endpackage

// ==== tb/cfg_bank_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module cfg_bank_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [23:0] fault_active,
    input wire logic frame_done,
    input wire logic frame_check_ok,
    input wire logic frame_check_enable,
    input wire logic frame_check_error,
    input wire logic coded_valid,
    input wire logic coded_input_disable,
    input wire logic coded_accept,
    input wire logic summary_fault_flag,
    input wire logic pwm_oe,
    input wire cfg_bank_pkg::pwm_mode_t pwm_mode
);
    import cfg_bank_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
    a_err: assert property (p_err) else $error("error answer not clean");
    property p_rsv; pready |-> prdata[31:24] == 8'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("upper read bits set");
    property p_flg; fault_active == 24'h00_0000 |=> !summary_fault_flag; endproperty
    a_flg: assert property (p_flg) else $error("flag without fault");
    property p_chk; frame_check_error |-> $past(frame_done && frame_check_enable && !frame_check_ok); endproperty
    a_chk: assert property (p_chk) else $error("spurious check error");
    property p_chn; frame_done && frame_check_enable && !frame_check_ok |=> frame_check_error; endproperty
    a_chn: assert property (p_chn) else $error("check error missed");
    property p_cod; coded_accept |-> $past(coded_valid && !coded_input_disable); endproperty
    a_cod: assert property (p_cod) else $error("coded input not ignored");
    property p_con; coded_valid && !coded_input_disable |=> coded_accept; endproperty
    a_con: assert property (p_con) else $error("coded input lost");
    property p_tri; pwm_mode == pwm_tristate |-> !pwm_oe; endproperty
    a_tri: assert property (p_tri) else $error("pwm driven in tristate");
endmodule
bind error_mask_pwm_angle_config cfg_bank_asserts chk_u (.pclk(pclk), .presetn(presetn), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fault_active(fault_active), .frame_done(frame_done),
    .frame_check_ok(frame_check_ok), .frame_check_enable(frame_check_enable),
    .frame_check_error(frame_check_error), .coded_valid(coded_valid), .coded_input_disable(coded_input_disable),
    .coded_accept(coded_accept), .summary_fault_flag(summary_fault_flag), .pwm_oe(pwm_oe), .pwm_mode(pwm_mode));
`default_nettype wire

// ==== tb/error_mask_pwm_angle_config_bench.sv ====
`timescale 1ns/1ns
`include "cfg_bank_defines.svh"
`default_nettype none
module error_mask_pwm_angle_config_bench;
    import cfg_bank_pkg::*;
    localparam logic [11:0] am = {`IDX_MASK, 2'b00};
    localparam logic [11:0] ap = {`IDX_PWI, 2'b00};
    localparam logic [11:0] aa = {`IDX_ANG, 2'b00};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic frame_done = 1'b0, frame_check_ok = 1'b0, coded_valid = 1'b0, sample_valid = 1'b0;
    logic [11:0] paddr = 12'h000, raw_angle = 12'h000, angle, turn_angle_register;
    logic [11:0] correction = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [23:0] fault_active = 24'h00_0000, warning_active = 24'h00_0000;
    logic pready, pslverr, se, summary_fault_flag, caution_summary_bit, frame_check_enable, extra_clock_ignore;
    logic coded_input_disable, frame_check_error, coded_accept, angle_valid, pwm_out, pwm_oe;
    pwm_mode_t pwm_mode;
    int n_fail = 0, comparisons = 0;
    always #20 pclk = ~pclk;
    error_mask_pwm_angle_config #(.PWM_UNIT(1)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid), .raw_angle(raw_angle), .correction(correction),
        .fault_active(fault_active), .warning_active(warning_active), .fault_duty(8'h80),
        .frame_done(frame_done), .frame_check_ok(frame_check_ok), .coded_valid(coded_valid),
        .summary_fault_flag(summary_fault_flag), .caution_summary_bit(caution_summary_bit),
        .frame_check_enable(frame_check_enable), .extra_clock_ignore(extra_clock_ignore),
        .coded_input_disable(coded_input_disable), .frame_check_error(frame_check_error),
        .coded_accept(coded_accept), .angle(angle), .angle_valid(angle_valid),
        .turn_angle_register(turn_angle_register), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .pwm_mode(pwm_mode));
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic ck(input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            n_fail++;
            tally_and_finish();
        end
        repeat (2) @(posedge pclk);
    endtask
    task automatic pulse(input logic f, input logic c, input logic s);
        frame_done <= f;
        coded_valid <= c;
        sample_valid <= s;
        @(posedge pclk);
        frame_done <= 1'b0;
        coded_valid <= 1'b0;
        sample_valid <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_regs;
        logic [11:0] a [3] = '{am, ap, aa};
        logic [23:0] m [3] = '{`MASK_WR, `PWI_WR, `ANG_WR};
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, a[i], 32'h0000_0000);
            ck(rd, 32'h0000_0000);
            bus(1'b1, a[i], 32'hffff_ffff);
            bus(1'b0, a[i], 32'h0000_0000);
            ck(rd, {8'h00, m[i]});
            bus(1'b1, a[i], 32'h0000_0000);
        end
        bus(1'b0, 12'h074, 32'h0000_0000);
        ck(se, 1'b1);
        $display("registers done");
    endtask
    task automatic t_mask;
        fault_active <= 24'h00_1000;
        warning_active <= 24'h00_0001;
        bus(1'b1, am, 32'h0000_1800);
        ck(summary_fault_flag, 1'b0);
        ck(caution_summary_bit, 1'b0);
        bus(1'b1, am, 32'h0000_0000);
        ck(summary_fault_flag, 1'b1);
        ck(caution_summary_bit, 1'b1);
        fault_active <= 24'h00_0000;
        warning_active <= 24'h00_0000;
        $display("masks done");
    endtask
    task automatic t_frame;
        bus(1'b1, ap, 32'h0000_0003);
        ck(frame_check_enable, 1'b1);
        ck(extra_clock_ignore, 1'b1);
        pulse(1'b1, 1'b1, 1'b0);
        ck(frame_check_error, 1'b1);
        ck(coded_accept, 1'b1);
        bus(1'b1, ap, 32'h0000_0008);
        pulse(1'b1, 1'b1, 1'b0);
        ck(frame_check_error, 1'b0);
        ck(coded_accept, 1'b0);
        bus(1'b1, ap, 32'h0000_0000);
        $display("frames done");
    endtask
    task automatic t_angle;
        bus(1'b1, aa, 32'h0000_0010);
        raw_angle <= 12'h100;
        pulse(1'b0, 1'b0, 1'b1);
        ck(angle, 12'h0f0);
        ck(angle_valid, 1'b1);
        bus(1'b1, aa, 32'h0008_0010);
        pulse(1'b0, 1'b0, 1'b1);
        ck(angle, 12'h8f0);
        bus(1'b1, aa, 32'h0010_0000);
        pulse(1'b0, 1'b0, 1'b1);
        ck(angle_valid, 1'b0);
        raw_angle <= 12'h200;
        pulse(1'b0, 1'b0, 1'b1);
        ck(angle, 12'h180);
        ck(turn_angle_register, 12'h200);
        bus(1'b1, aa, 32'h0000_0000);
        $display("angles done");
    endtask
    task automatic t_path;
        correction <= 12'h080;
        raw_angle <= 12'h100;
        bus(1'b1, ap, 32'h0000_0800);
        pulse(1'b0, 1'b0, 1'b1);
        ck(angle, 12'h0f0);
        bus(1'b1, ap, 32'h0000_0c00);
        pulse(1'b0, 1'b0, 1'b1);
        ck(angle, 12'h0e0);
        bus(1'b1, ap, 32'h0000_0000);
        pulse(1'b0, 1'b0, 1'b1);
        ck(angle, 12'h100);
        bus(1'b1, aa, 32'h0004_0000);
        pulse(1'b0, 1'b0, 1'b1);
        ck(angle, 12'hf00);
        bus(1'b1, aa, 32'h0000_0000);
        correction <= 12'h000;
        $display("paths done");
    endtask
    task automatic t_pwm;
        bus(1'b1, ap, 32'h0080_0000);
        ck(pwm_oe, 1'b1);
        fault_active <= 24'h00_1000;
        bus(1'b1, ap, 32'h0080_2000);
        ck(pwm_mode, pwm_tristate);
        fault_active <= 24'h00_0000;
        repeat (4) @(posedge pclk);
        ck(pwm_mode, pwm_tristate);
        fault_active <= 24'h00_1000;
        bus(1'b1, ap, 32'h0080_0000);
        ck(pwm_mode, pwm_normal);
        ck(pwm_oe, 1'b1);
        bus(1'b1, ap, 32'h0080_3000);
        ck(pwm_mode, pwm_fault_duty);
        fault_active <= 24'h00_0000;
        bus(1'b1, ap, 32'h0000_0000);
        ck(pwm_oe, 1'b0);
        $display("pwm done");
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_mask();
        t_frame();
        t_angle();
        t_path();
        t_pwm();
        tally_and_finish();
    end
endmodule
`default_nettype wire
